// [design/sent_pkg.sv]
//==============================================================
// Purpose: Shared constants and carriers for the SENT output block
// Assumes: 125 MHz REF_CLK, config words loaded from non-volatile store
// Notes:   Field positions index into 24-bit configuration words
package sent_pkg;
  // Configuration word offsets (non-volatile addresses)
  localparam logic [7:0] SENT_FRAME_CONFIG_ADDR = 8'h17;
  localparam logic [7:0] CUSTOMER_CONFIG_ONE_ADDR = 8'h18;
  localparam logic [7:0] CUSTOMER_CONFIG_TWO_ADDR = 8'h19;
  localparam logic [7:0] ERROR_MASK_CONFIG_ADDR = 8'h1E;
  localparam logic [7:0] CUSTOMER_SCRATCH_WORD_ADDR = 8'h1F;
  // Fields of sent_frame_config
  localparam int DRIVE_LSB = 0;
  localparam int DRIVE_W = 3;
  localparam int TICK_LSB = 3;
  localparam int TICK_W = 8;
  localparam int MODE_LSB = 11;
  localparam int MODE_W = 3;
  localparam int SERIAL_LSB = 17;
  localparam int SERIAL_W = 2;
  localparam int PAUSE_BIT = 20;
  // Fields of customer_config_one
  localparam int THRESH_LSB = 0;
  localparam int THRESH_W = 11;
  localparam int SHARED_ID_LSB = 11;
  localparam int SHARED_ID_W = 3;
  // First error status word bit positions
  localparam int SUPPLY_LOSS_BIT = 0;
  localparam int MAGNET_LOSS_BIT = 1;
  localparam int LOGIC_FAULT_BIT = 2;
  localparam int TEMP_RANGE_BIT = 4;
  localparam int CORRECTED_BIT = 5;
  localparam int UNCORRECTABLE_BIT = 6;
  localparam logic [12:0] ERR_RESET_VALUE = 13'h0001;
  // Second error status word bit positions
  localparam int RING_TEST_BIT = 3;
  localparam int LOGIC_TEST_BIT = 4;
  // Frame timing in ticks
  localparam logic [6:0] LOW_TICKS = 7'd5;
  localparam logic [6:0] NIBBLE_BASE_TICKS = 7'd12;
  localparam logic [6:0] SYNC_TICKS = 7'd56;
  localparam logic [6:0] PAUSE_TICKS = 7'd64;
  localparam logic [3:0] CRC_SEED = 4'h5;
  // Self-test timing
  localparam int CLK_MHZ = 125;
  localparam int LOGIC_TEST_MS = 10;
  localparam int LOGIC_TEST_CYCLES = LOGIC_TEST_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int RING_DWELL_CYCLES = 8192;
  localparam int RING_ELEMENTS = 16;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {MODE_STANDARD, MODE_TRIGGERED, MODE_ADDRESSED, MODE_POLLED}
    sent_mode_e;

  typedef struct packed {
    logic [23:0] sent_frame_config;
    logic [23:0] customer_config_one;
    logic [23:0] customer_config_two;
    logic [23:0] error_mask_config;
    logic [23:0] customer_scratch_word;
  } config_words_s;

  typedef struct packed {
    logic [3:0] status;
    logic [11:0] angle;
    logic [3:0] crc;
  } sent_frame_s;
endpackage

// [design/sample_fifo.sv]
//==============================================================
// Purpose: Small valid/ready FIFO for angle samples
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; no bypass path
module sample_fifo
  import sent_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // Pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [design/sent_output.sv]
//==============================================================
// Purpose: SENT frame transmitter with diagnostic flag keeping
// Assumes: Config words stable while frames run; angle input on REF_CLK
// Notes:   Line is open drain: low phase drives, high phase releases
// Behaviour
// - Angle scaled to 12-bit code, sent
// - Each nibble is low then high interval
// - Low interval always five ticks
// - High interval 7 to 22 ticks
// - Nibble totals 12 to 27 ticks
// - Tick period from tick-period config field
// - Frame order sync, status, data, CRC, pause
// - Status nibble carries status and serial bits
// - Standard mode streams frames unrequested
// - Triggered mode sends only on request
// - Shared line, addressed or polled devices
// - Falling slew set by drive field
// - Logic self-test records pass or fail
// - Logic test 10 ms, failures flagged
// - Ring self-test entered on request
// - Ring test biases each element, stores angles
// - Corrected and uncorrectable word flags
// - Internal logic fault flag
// - Magnet loss below field threshold
// - Supply loss flag set
// - Undervoltage drives separate UNDERVOLT_BIT output
// - All diagnostic flags readable
// - Supply flag set at start, host clears
// - Status word flags sticky until error reset; UNDERVOLT_BIT follows the pin
module sent_output
  import sent_pkg::*;
#(
  parameter int LOGIC_TEST_LEN = LOGIC_TEST_CYCLES,
  parameter int RING_DWELL = RING_DWELL_CYCLES
)
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire config_words_s CONFIG,
  input wire logic ANGLE_VALID,
  input wire logic [15:0] ANGLE_RAW,
  output logic ANGLE_READY,
  input wire logic FRAME_REQ_PIN,
  input wire logic [2:0] FRAME_REQ_ID,
  input wire logic UNDERVOLT_PIN,
  input wire logic SUPPLY_LOST_PIN,
  input wire logic TEMP_BAD_PIN,
  input wire logic [10:0] FIELD_LEVEL,
  input wire logic WORD_CORRECTED,
  input wire logic WORD_UNCORRECTABLE,
  input wire logic LOGIC_FAULT,
  input wire logic ERROR_RESET,
  input wire logic LOGIC_TEST_START,
  input wire logic LOGIC_TEST_MISMATCH,
  input wire logic RING_TEST_REQ,
  input wire logic RING_ELEMENT_FAULT,
  input wire logic [3:0] RING_READ_IDX,
  output logic SENT_OUT,
  output logic SENT_OE_N,
  output logic [2:0] SENT_DRIVE,
  output logic [12:0] ERROR_STATUS,
  output logic [12:0] SECOND_ERROR_STATUS,
  output logic ERROR_ANY,
  output logic UNDERVOLT_BIT,
  output logic LOGIC_TEST_BUSY,
  output logic RING_BIAS_EN,
  output logic [3:0] RING_BIAS_SEL,
  output logic [11:0] RING_READ_ANGLE
);
  typedef enum logic [0:0] {FR_WAIT, FR_PULSE} frame_state_e;
  localparam int NSYNC = 4;

  //==============================================================
  // Pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_meta;
  logic [NSYNC-1:0] pin_sync;
  logic req_prev;
  assign pin_raw = {FRAME_REQ_PIN, TEMP_BAD_PIN, SUPPLY_LOST_PIN, UNDERVOLT_PIN};

  // Two flops per pin; first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge REF_CLK)
      begin
        if (RESET)
        begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic undervolt;
  logic supply_lost;
  logic temp_bad;
  logic req_pulse;
  assign undervolt = pin_sync[0];
  assign supply_lost = pin_sync[1];
  assign temp_bad = pin_sync[2];
  assign req_pulse = pin_sync[3] && !req_prev;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      req_prev <= 1'b0;
    else
      req_prev <= pin_sync[3];
  end

  //==============================================================
  // Config decode
  sent_mode_e mode;
  logic [TICK_W-1:0] tick_field;
  logic [SERIAL_W-1:0] serial_sel;
  logic pause_en;
  logic [2:0] shared_id;
  assign mode = sent_mode_e'(CONFIG.sent_frame_config[MODE_LSB +: MODE_W]);
  assign tick_field = CONFIG.sent_frame_config[TICK_LSB +: TICK_W];
  assign serial_sel = CONFIG.sent_frame_config[SERIAL_LSB +: SERIAL_W];
  assign pause_en = CONFIG.sent_frame_config[PAUSE_BIT];
  assign shared_id = CONFIG.customer_config_one[SHARED_ID_LSB +: SHARED_ID_W];

  // Drive strength word passes to the pad slew control
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      SENT_DRIVE <= '0;
    else
      SENT_DRIVE <= CONFIG.sent_frame_config[DRIVE_LSB +: DRIVE_W];
  end

  //==============================================================
  // Angle sample buffer; top 12 bits give the full-turn code
  logic fifo_out_valid;
  logic fifo_pop;
  logic [11:0] fifo_out_data;
  sample_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(REF_CLK),
    .reset(RESET),
    .in_valid(ANGLE_VALID),
    .in_ready(ANGLE_READY),
    .in_data(ANGLE_RAW[15:4]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  //==============================================================
  // Tick generator: field of zero is treated as one cycle; restarted at frame start
  logic [TICK_W-1:0] div_cnt;
  logic start_frame;
  logic frame_end;
  logic tick;
  assign tick = (div_cnt == '0);

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      div_cnt <= '0;
    else if (tick || start_frame)
      div_cnt <= (tick_field == '0) ? '0 : tick_field - 1'b1;
    else
      div_cnt <= div_cnt - 1'b1;
  end

  //==============================================================
  // Frame content
  function automatic logic [3:0] crc4(input logic [15:0] nibs);
    logic [3:0] tbl [16];
    logic [3:0] c;
    tbl = '{4'h0, 4'hD, 4'h7, 4'hA, 4'hE, 4'h3, 4'h9, 4'h4,
            4'h1, 4'hC, 4'h6, 4'hB, 4'hF, 4'h2, 4'h8, 4'h5};
    c = CRC_SEED;
    for (int i = 3; i >= 0; i--)
      c = nibs[i*4 +: 4] ^ tbl[c];
    c = tbl[c];
    return c;
  endfunction

  frame_state_e state;
  sent_frame_s frame;
  sent_frame_s next_frame;
  logic [11:0] last_angle;
  logic [2:0] seg;
  logic [6:0] tick_cnt;
  logic [6:0] seg_len;
  logic [2:0] poll_slot;
  logic frame_count;
  logic req_hit;

  // Triggered mode waits for any request, shared modes for a matching one
  always_comb
  begin
    case (mode)
      MODE_STANDARD: req_hit = 1'b1;
      MODE_TRIGGERED: req_hit = req_pulse;
      MODE_ADDRESSED: req_hit = req_pulse && (FRAME_REQ_ID == shared_id);
      MODE_POLLED: req_hit = req_pulse && (poll_slot == shared_id);
      default: req_hit = 1'b0;
    endcase
  end

  // Standard mode chains frames with no idle cycle, so the crc nibble keeps its length
  assign frame_end = (state == FR_PULSE) && tick && (tick_cnt == seg_len - 1'b1)
    && (seg == 3'd6 || (seg == 3'd5 && !pause_en));
  assign start_frame = req_hit && ((state == FR_WAIT) || (frame_end && mode == MODE_STANDARD));
  assign fifo_pop = start_frame;

  // Oldest buffered sample if one waits, otherwise the last one sent
  always_comb
  begin
    next_frame.angle = fifo_out_valid ? fifo_out_data : last_angle;
    next_frame.status[1:0] = {1'b0, ERROR_ANY};
    next_frame.status[3:2] = (serial_sel == '0) ? 2'b00 : {frame_count, serial_sel[0]};
    next_frame.crc = crc4({next_frame.status, next_frame.angle});
  end

  // Pulse length: sync, four content nibbles then crc, optional pause
  always_comb
  begin
    case (seg)
      3'd0: seg_len = SYNC_TICKS;
      3'd1: seg_len = NIBBLE_BASE_TICKS + {3'b000, frame.status};
      3'd2: seg_len = NIBBLE_BASE_TICKS + {3'b000, frame.angle[11:8]};
      3'd3: seg_len = NIBBLE_BASE_TICKS + {3'b000, frame.angle[7:4]};
      3'd4: seg_len = NIBBLE_BASE_TICKS + {3'b000, frame.angle[3:0]};
      3'd5: seg_len = NIBBLE_BASE_TICKS + {3'b000, frame.crc};
      default: seg_len = PAUSE_TICKS;
    endcase
  end

  // Frame sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state <= FR_WAIT;
      seg <= '0;
      tick_cnt <= '0;
      frame <= '0;
      last_angle <= '0;
      frame_count <= 1'b0;
    end
    else if (start_frame)
    begin
      frame <= next_frame;
      last_angle <= next_frame.angle;
      frame_count <= !frame_count;
      seg <= '0;
      tick_cnt <= '0;
      state <= FR_PULSE;
    end
    else
    begin
      case (state)
        FR_WAIT:
          state <= FR_WAIT;
        FR_PULSE:
          if (tick)
          begin
            if (tick_cnt == seg_len - 1'b1)
            begin
              tick_cnt <= '0;
              if (seg == 3'd6 || (seg == 3'd5 && !pause_en))
                state <= FR_WAIT;
              else
                seg <= seg + 1'b1;
            end
            else
              tick_cnt <= tick_cnt + 1'b1;
          end
        default:
          state <= FR_WAIT;
      endcase
    end
  end

  // Polled slot advances on every request seen on the shared line
  always_ff @(posedge REF_CLK)
  begin
    if (RESET || mode != MODE_POLLED)
      poll_slot <= '0;
    else if (req_pulse)
      poll_slot <= poll_slot + 1'b1;
  end

  // Line drive: low for the first five ticks of each pulse
  logic line_low;
  assign line_low = (state == FR_PULSE) && (tick_cnt < LOW_TICKS);
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      SENT_OUT <= 1'b1;
      SENT_OE_N <= 1'b1;
    end
    else
    begin
      SENT_OUT <= !line_low;
      SENT_OE_N <= !line_low;
    end
  end

  //==============================================================
  // Logic self-test timer
  logic [31:0] lt_cnt;
  logic lt_fail;
  logic lt_done;
  assign lt_done = LOGIC_TEST_BUSY && (lt_cnt == 32'(LOGIC_TEST_LEN - 1));

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      LOGIC_TEST_BUSY <= 1'b0;
      lt_cnt <= '0;
      lt_fail <= 1'b0;
    end
    else if (!LOGIC_TEST_BUSY)
    begin
      if (LOGIC_TEST_START)
      begin
        LOGIC_TEST_BUSY <= 1'b1;
        lt_cnt <= '0;
        lt_fail <= 1'b0;
      end
    end
    else
    begin
      lt_cnt <= lt_cnt + 1'b1;
      lt_fail <= lt_fail || LOGIC_TEST_MISMATCH;
      if (lt_done)
        LOGIC_TEST_BUSY <= 1'b0;
    end
  end

  //==============================================================
  // Ring self-test: dwell on each element, keep its angle
  logic [31:0] ring_cnt;
  logic ring_fail;
  logic ring_done;
  logic [11:0] ring_angle [RING_ELEMENTS];
  logic ring_step;
  assign ring_step = RING_BIAS_EN && (ring_cnt == 32'(RING_DWELL - 1));
  assign ring_done = ring_step && (RING_BIAS_SEL == 4'(RING_ELEMENTS - 1));

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      RING_BIAS_EN <= 1'b0;
      RING_BIAS_SEL <= '0;
      ring_cnt <= '0;
      ring_fail <= 1'b0;
    end
    else if (!RING_BIAS_EN)
    begin
      if (RING_TEST_REQ)
      begin
        RING_BIAS_EN <= 1'b1;
        RING_BIAS_SEL <= '0;
        ring_cnt <= '0;
        ring_fail <= 1'b0;
      end
    end
    else
    begin
      ring_fail <= ring_fail || RING_ELEMENT_FAULT;
      ring_cnt <= ring_step ? '0 : ring_cnt + 1'b1;
      if (ring_done)
        RING_BIAS_EN <= 1'b0;
      else if (ring_step)
        RING_BIAS_SEL <= RING_BIAS_SEL + 1'b1;
    end
  end

  // Angle store, one word per element, captured at end of dwell
  always_ff @(posedge REF_CLK)
  begin
    if (ring_step)
      ring_angle[RING_BIAS_SEL] <= ANGLE_RAW[15:4];
    RING_READ_ANGLE <= ring_angle[RING_READ_IDX];
  end

  //==============================================================
  // Sticky error flags; a set in the clearing cycle survives
  logic [12:0] err_set;
  logic [12:0] second_error_status_set;
  logic [12:0] err_masked;
  logic magnet_low;
  assign magnet_low = FIELD_LEVEL < CONFIG.customer_config_one[THRESH_LSB +: THRESH_W];

  always_comb
  begin
    err_set = '0;
    err_set[SUPPLY_LOSS_BIT] = supply_lost;
    err_set[MAGNET_LOSS_BIT] = magnet_low;
    err_set[LOGIC_FAULT_BIT] = LOGIC_FAULT;
    err_set[TEMP_RANGE_BIT] = temp_bad;
    err_set[CORRECTED_BIT] = WORD_CORRECTED;
    err_set[UNCORRECTABLE_BIT] = WORD_UNCORRECTABLE;
    second_error_status_set = '0;
    second_error_status_set[LOGIC_TEST_BIT] = lt_done && (lt_fail || LOGIC_TEST_MISMATCH);
    second_error_status_set[RING_TEST_BIT] = ring_done && (ring_fail || RING_ELEMENT_FAULT);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ERROR_STATUS <= ERR_RESET_VALUE;
      SECOND_ERROR_STATUS <= '0;
    end
    else
    begin
      ERROR_STATUS <= (ERROR_RESET ? '0 : ERROR_STATUS) | err_set;
      SECOND_ERROR_STATUS <= (ERROR_RESET ? '0 : SECOND_ERROR_STATUS) | second_error_status_set;
    end
  end

  // Masked bits stay visible but do not raise the summary
  assign err_masked = ERROR_STATUS & ~CONFIG.error_mask_config[12:0];
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ERROR_ANY <= 1'b0;
      UNDERVOLT_BIT <= 1'b0;
    end
    else
    begin
      ERROR_ANY <= (|err_masked) || (|SECOND_ERROR_STATUS);
      UNDERVOLT_BIT <= undervolt;
    end
  end

  //==============================================================
  // Checks
  sequence s_low_phase;
    !SENT_OE_N [*1] ##1 (!SENT_OE_N || tick) [*1];
  endsequence

  property p_low_ends_high;
    @(posedge REF_CLK) disable iff (RESET)
      (state == FR_PULSE && tick && tick_cnt == LOW_TICKS - 1'b1) |=> ##1 SENT_OE_N;
  endproperty
  a_low_ends_high: assert property (p_low_ends_high) else $error("low phase too long");

  property p_low_at_pulse_start;
    @(posedge REF_CLK) disable iff (RESET)
      (state == FR_PULSE && tick_cnt == '0) |=> s_low_phase;
  endproperty
  a_low_at_pulse_start: assert property (p_low_at_pulse_start) else $error("no low phase");

  property p_out_tracks_oe;
    @(posedge REF_CLK) disable iff (RESET) SENT_OUT == SENT_OE_N;
  endproperty
  a_out_tracks_oe: assert property (p_out_tracks_oe) else $error("line level mismatch");

  property p_nibble_len;
    @(posedge REF_CLK) disable iff (RESET)
      (state == FR_PULSE && seg inside {[3'd1:3'd5]}) |-> seg_len inside {[7'd12:7'd27]};
  endproperty
  a_nibble_len: assert property (p_nibble_len) else $error("nibble length out of range");

  property p_frame_starts_sync;
    @(posedge REF_CLK) disable iff (RESET) start_frame |=> (seg == '0 && seg_len == SYNC_TICKS);
  endproperty
  a_frame_starts_sync: assert property (p_frame_starts_sync) else $error("frame not sync");

  property p_triggered_waits;
    @(posedge REF_CLK) disable iff (RESET)
      (mode == MODE_TRIGGERED && state == FR_WAIT && !req_pulse) |=> state == FR_WAIT;
  endproperty
  a_triggered_waits: assert property (p_triggered_waits) else $error("unrequested frame");

  property p_crc_match;
    @(posedge REF_CLK) disable iff (RESET)
      state == FR_PULSE |-> frame.crc == crc4({frame.status, frame.angle});
  endproperty
  a_crc_match: assert property (p_crc_match) else $error("crc mismatch");

  property p_flag_sticky;
    @(posedge REF_CLK) disable iff (RESET)
      (ERROR_STATUS[MAGNET_LOSS_BIT] && !ERROR_RESET) |=> ERROR_STATUS[MAGNET_LOSS_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_magnet_sets;
    @(posedge REF_CLK) disable iff (RESET) magnet_low |=> ERROR_STATUS[MAGNET_LOSS_BIT];
  endproperty
  a_magnet_sets: assert property (p_magnet_sets) else $error("magnet flag missed");

  property p_undervolt;
    @(posedge REF_CLK) disable iff (RESET) $rose(undervolt) |=> UNDERVOLT_BIT;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervolt bit late");

  property p_logic_test_ends;
    @(posedge REF_CLK) disable iff (RESET) lt_done |=> !LOGIC_TEST_BUSY;
  endproperty
  a_logic_test_ends: assert property (p_logic_test_ends) else $error("logic test overran");
endmodule

// [sim/sent_rx_model.sv]
//==============================================================
// Purpose: Receiver model that times the SENT line edge to edge
// Assumes: Line pulled up whenever the transmitter releases it
// Notes:   Samples on the falling clock edge to stay clear of races
module sent_rx_model
#(
  parameter int TICK = 2
)
(
  input wire logic clk,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  int per_q[$];
  int low_bad = 0;
  int cnt = 0;
  int low_len = 0;
  logic line_q = 1'b1;
  //==============================================================
  // Edge timing
  // Periods between falling edges are queued; low widths judged here
  always @(negedge clk)
  begin
    cnt++;
    if (!line)
      low_len++;
    if (line_q && !line)
    begin
      per_q.push_back(cnt);
      cnt = 0;
      low_len = 1;
    end
    if (!line_q && line && low_len != 5 * TICK)
      low_bad++;
    line_q = line;
  end
endmodule

// [sim/sent_frame_output_diagnostics_tb.sv]
//==============================================================
// Purpose: Self-checking bench for the SENT transmitter and flags
// Assumes: Tick field of 2 cycles; shortened self-test lengths
// Notes:   Frames are decoded from edge timing by the receiver model
module sent_frame_output_diagnostics_tb
  import sent_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 2;
  logic clk, rst, a_valid, a_ready, req, uv, error_reset_bit, lt_start, lt_mis, rg_req, rg_fault;
  logic s_out, s_oe_n, err_any, uv_bit, lt_busy, rg_en;
  logic [15:0] a_raw;
  logic [5:0] src;
  logic [2:0] req_id, drive;
  logic [12:0] err1, second_error_status;
  logic [3:0] rg_sel, rg_idx;
  logic [11:0] rg_ang;
  config_words_s cfg;
  int err_count = 0;
  int checks = 0;

  sent_output #(.LOGIC_TEST_LEN(50), .RING_DWELL(8)) dut_u (
    .REF_CLK(clk), .RESET(rst), .CONFIG(cfg), .ANGLE_VALID(a_valid), .ANGLE_RAW(a_raw),
    .ANGLE_READY(a_ready), .FRAME_REQ_PIN(req), .FRAME_REQ_ID(req_id), .UNDERVOLT_PIN(uv),
    .SUPPLY_LOST_PIN(src[3]), .TEMP_BAD_PIN(src[4]),
    .FIELD_LEVEL(src[5] ? 11'h000 : 11'h7FF), .WORD_CORRECTED(src[1]),
    .WORD_UNCORRECTABLE(src[2]), .LOGIC_FAULT(src[0]), .ERROR_RESET(error_reset_bit),
    .LOGIC_TEST_START(lt_start), .LOGIC_TEST_MISMATCH(lt_mis), .RING_TEST_REQ(rg_req),
    .RING_ELEMENT_FAULT(rg_fault), .RING_READ_IDX(rg_idx), .SENT_OUT(s_out),
    .SENT_OE_N(s_oe_n), .SENT_DRIVE(drive), .ERROR_STATUS(err1),
    .SECOND_ERROR_STATUS(second_error_status), .ERROR_ANY(err_any), .UNDERVOLT_BIT(uv_bit),
    .LOGIC_TEST_BUSY(lt_busy), .RING_BIAS_EN(rg_en), .RING_BIAS_SEL(rg_sel),
    .RING_READ_ANGLE(rg_ang)
  );
  sent_rx_model #(.TICK(TK)) rx_u (.clk(clk), .line(s_oe_n));

  //==============================================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //==============================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic stop_test;
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Distinct codes, first one all ones to hit the longest nibble
  function automatic logic [11:0] code_of(input int k);
    return 12'hFFF - 12'(k) * 12'h111;
  endfunction

  // Table-free form of the four-bit checksum, seed then trailing zero
  function automatic logic [3:0] crc_of(input logic [15:0] d);
    logic [3:0] c;
    logic [19:0] s;
    c = CRC_SEED;
    s = {d, 4'h0};
    repeat (5)
    begin
      repeat (4)
        c = c[3] ? {c[2:0], 1'b0} ^ 4'hD : {c[2:0], 1'b0};
      c = c ^ s[19:16];
      s = s << 4;
    end
    return c;
  endfunction

  task automatic get_frame(output logic [19:0] f);
    int p;
    p = 0;
    f = '0;
    rx_u.per_q.delete();
    while (p != int'(SYNC_TICKS) * TK)
    begin
      wait (rx_u.per_q.size() > 0);
      p = rx_u.per_q.pop_front();
    end
    repeat (5)
    begin
      wait (rx_u.per_q.size() > 0);
      p = rx_u.per_q.pop_front();
      f = {f[15:0], 4'(p / TK - 12)};
    end
  endtask

  task automatic check_frame(input logic [11:0] code);
    logic [19:0] f;
    get_frame(f);
    check("status", f[19:16], 4'h0);
    check("angle", f[15:4], code);
    check("crc", f[3:0], crc_of({4'h0, code}));
  endtask

  task automatic clear_errs;
    error_reset_bit = 1'b1;
    cycles(1);
    error_reset_bit = 1'b0;
    cycles(2);
    check("cleared", err1, 13'h0000);
    check("cleared2", second_error_status, 13'h0000);
  endtask

  //==============================================================
  // Scenarios
  task automatic do_reset(input logic [2:0] mode, input logic [12:0] mask);
    // Pause after the crc gives its closing edge when frames do not chain
    cfg.sent_frame_config = 24'(mode) << MODE_LSB | 24'(TK) << TICK_LSB | 24'h5
      | 24'(mode != 3'h0) << PAUSE_BIT;
    cfg.error_mask_config = 24'(mask);
    rst = 1'b1;
    cycles(10);
    check("reset line", s_oe_n, 1'b1);
    check("reset errors", err1, 13'h0001);
    rst = 1'b0;
  endtask

  task automatic test_flags;
    int pos [6] = '{LOGIC_FAULT_BIT, CORRECTED_BIT, UNCORRECTABLE_BIT, SUPPLY_LOSS_BIT,
                    TEMP_RANGE_BIT, MAGNET_LOSS_BIT};
    clear_errs();
    check("any idle", err_any, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      src[i] = 1'b1;
      cycles(4);
      src[i] = 1'b0;
      cycles(4);
      check("flag", err1, 13'(1 << pos[i]));
      check("any", err_any, 1'b1);
      clear_errs();
    end
    uv = 1'b1;
    cycles(4);
    check("undervolt", uv_bit, 1'b1);
    uv = 1'b0;
  endtask

  task automatic test_selftests;
    int n;
    lt_mis = 1'b1;
    lt_start = 1'b1;
    cycles(1);
    lt_start = 1'b0;
    for (n = 0; lt_busy === 1'b1 && n < 200; n++)
      cycles(1);
    cycles(2);
    check("logic test length", 16'(n), 16'd50);
    check("logic test fail", second_error_status[LOGIC_TEST_BIT], 1'b1);
    a_raw = 16'hABC0;
    rg_fault = 1'b1;
    rg_req = 1'b1;
    cycles(1);
    rg_req = 1'b0;
    for (n = 0; rg_en === 1'b1 && n < 400; n++)
      cycles(1);
    cycles(2);
    check("ring test length", 16'(n), 16'(RING_ELEMENTS * 8));
    check("ring test fail", second_error_status[RING_TEST_BIT], 1'b1);
    check("ring angle", rg_ang, 12'hABC);
    check("ring last element", rg_sel, 4'hF);
    lt_mis = 1'b0;
    rg_fault = 1'b0;
    clear_errs();
  endtask

  // Fill the sample buffer until it refuses, then drain it frame by frame
  task automatic test_stream;
    int k;
    int n;
    logic [19:0] f;
    k = 0;
    a_valid = 1'b1;
    while (a_ready === 1'b1 && k < 12)
    begin
      a_raw = {code_of(k), 4'h0};
      cycles(1);
      k++;
    end
    a_valid = 1'b0;
    check("fifo full", a_ready, 1'b0);
    check("fifo depth", 16'(k >= FIFO_DEPTH), 16'h1);
    f = '0;
    for (n = 0; f[15:4] !== code_of(0) && n < 4; n++)
      get_frame(f);
    check("first angle", f[15:4], code_of(0));
    for (int j = 1; j < k; j++)
      check_frame(code_of(j));
    check_frame(code_of(k - 1));
    check("fifo drained", a_ready, 1'b1);
    check("low width", 16'(rx_u.low_bad), 16'h0);
    check("drive", drive, 3'h5);
    check("line copy", s_out, s_oe_n);
  endtask

  // Receiver-side requests; supply flag masked so the status stays zero
  task automatic test_request(input logic [2:0] mode, input logic [2:0] id, input bit want);
    do_reset(mode, 13'h0001);
    rx_u.per_q.delete();
    cycles(300);
    check("silent", 16'(rx_u.per_q.size()), 16'h0);
    req_id = id;
    req = 1'b1;
    cycles(2);
    req = 1'b0;
    if (want)
      check_frame(12'h000);
    else
    begin
      cycles(400);
      check("ignored", 16'(rx_u.per_q.size()), 16'h0);
    end
  endtask

  //==============================================================
  // Main sequence and watchdog
  initial
  begin
    {rst, a_valid, req, uv, error_reset_bit, lt_start, lt_mis, rg_req, rg_fault} = '0;
    a_raw = '0;
    src = '0;
    req_id = '0;
    rg_idx = 4'h9;
    cfg = '0;
    cfg.customer_config_one = 24'(3) << SHARED_ID_LSB | 24'h064;
    do_reset(MODE_STANDARD, 13'h0000);
    test_flags();
    test_selftests();
    test_stream();
    test_request(MODE_TRIGGERED, 3'h0, 1'b1);
    test_request(MODE_ADDRESSED, 3'h5, 1'b0);
    test_request(MODE_ADDRESSED, 3'h3, 1'b1);
    test_request(MODE_POLLED, 3'h3, 1'b0);
    stop_test();
  end

  initial
  begin
    #(60000 * 8);
    err_count++;
    stop_test();
  end
endmodule
